// File: hw/urf_pkg.sv
// package: constants and types for the unified register file
package urf_pkg;
    localparam int unsigned URF_NREG = 64;
    localparam int unsigned URF_AW = 6;
    localparam int unsigned URF_DW = 64;
    localparam logic [5:0] URF_ZERO_IDX = 6'h00;
    localparam logic [63:0] URF_ZERO_VAL = 64'h0000_0000_0000_0000;
    localparam logic [5:0] URF_CARRY_STEP = 6'h01;
    typedef logic [5:0] urf_addr_t;
    typedef logic [63:0] urf_data_t;
    typedef enum logic [0:0] {URF_IDLE, URF_WAIT} urf_ptr_state_t;
endpackage : urf_pkg

// File: hw/urf_wr_if.sv
// interface: one register write request between the top and the attribute array
`timescale 1ns/100ps
interface urf_wr_if;
    logic en;
    urf_pkg::urf_addr_t addr;
    urf_pkg::urf_data_t data;
    modport src (output en, output addr, output data);
    modport dst (input en, input addr, input data);
endinterface : urf_wr_if

// File: hw/urf_zattr.sv
// module: zero attribute array, one entry updated on each write to a nonzero register
`timescale 1ns/100ps
module urf_zattr
    import urf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // write snoop
    urf_wr_if.dst wr,
    // attribute bits
    output logic [URF_NREG-1:0] zero_ff
);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            zero_ff <= '1;
        end else begin
            if (wr.en && wr.addr != URF_ZERO_IDX) begin
                zero_ff[wr.addr] <= (wr.data == URF_ZERO_VAL);
            end
            zero_ff[URF_ZERO_IDX] <= 1'b1;
        end
    end
endmodule : urf_zattr

// File: hw/urf_top.sv
// module: unified register file with zero attributes, carry and pointer writeback
`timescale 1ns/100ps
module urf_top
    import urf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // read ports
    input wire urf_addr_t rd_addr_a,
    input wire urf_addr_t rd_addr_b,
    input wire urf_addr_t rd_addr_c,
    output urf_data_t rd_data_a_ff,
    output urf_data_t rd_data_b_ff,
    output urf_data_t rd_data_c_ff,
    // result write with optional carry
    input wire logic wr_en,
    input wire urf_addr_t wr_addr,
    input wire urf_data_t wr_data,
    input wire logic wr_carry_en,
    input wire urf_data_t wr_carry_data,
    // condition test
    input wire urf_addr_t cond_addr,
    input wire logic cond_on_zero,
    output logic cond_zero_ff,
    output logic cond_take_ff,
    // pointer access
    input wire logic ptr_start,
    input wire urf_addr_t ptr_addr,
    input wire urf_data_t ptr_disp,
    input wire logic mem_done,
    output urf_data_t mem_addr_ff,
    output logic mem_req_ff,
    output logic ptr_busy_ff
);
    // ****************
    // storage
    // ****************
    urf_data_t regs [URF_NREG];
    urf_ptr_state_t state_ff;
    urf_addr_t ptr_idx_ff;
    urf_data_t ptr_new_ff;
    logic ptr_wb;
    logic [URF_NREG-1:0] zero_vec;
    urf_wr_if wbus ();
    urf_wr_if cbus ();

    function automatic logic live_idx(input urf_addr_t a);
        live_idx = (a != URF_ZERO_IDX);
    endfunction : live_idx

    function automatic urf_addr_t carry_idx(input urf_addr_t a);
        carry_idx = urf_addr_t'(a + URF_CARRY_STEP);
    endfunction : carry_idx

    function automatic urf_data_t rd_val(input urf_addr_t a);
        rd_val = live_idx(a) ? regs[a] : URF_ZERO_VAL;
    endfunction : rd_val

    // ****************
    // write arbitration
    // ****************
    // pointer writeback owns the port; a result write in that cycle is lost
    assign ptr_wb = (state_ff == URF_WAIT) && mem_done;
    assign wbus.en = ptr_wb || wr_en;
    assign wbus.addr = ptr_wb ? ptr_idx_ff : wr_addr;
    assign wbus.data = ptr_wb ? ptr_new_ff : wr_data;
    assign cbus.en = wr_en && wr_carry_en && !ptr_wb;
    assign cbus.addr = carry_idx(wr_addr);
    assign cbus.data = wr_carry_data;

    // ****************
    // register writes
    // ****************
    // contents have no reset; only the zero register is defined before a write
    always_ff @(posedge clk) begin
        if (wbus.en && live_idx(wbus.addr)) begin
            regs[wbus.addr] <= wbus.data;
        end
        if (cbus.en && live_idx(cbus.addr)) begin
            regs[cbus.addr] <= cbus.data;
        end
    end

    // ****************
    // zero attributes
    // ****************
    urf_zattr u_zattr_w (
        .clk(clk),
        .rst_b(rst_b),
        .wr(wbus),
        .zero_ff(zero_vec)
    );
    logic [URF_NREG-1:0] zero_c;
    urf_zattr u_zattr_c (
        .clk(clk),
        .rst_b(rst_b),
        .wr(cbus),
        .zero_ff(zero_c)
    );
    // track which array last wrote each register
    logic [URF_NREG-1:0] src_c_ff;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            src_c_ff <= '0;
        end else begin
            if (wbus.en) begin
                src_c_ff[wbus.addr] <= 1'b0;
            end
            if (cbus.en) begin
                src_c_ff[cbus.addr] <= 1'b1;
            end
        end
    end

    // ****************
    // condition test
    // ****************
    logic cond_z;
    assign cond_z = src_c_ff[cond_addr] ? zero_c[cond_addr] : zero_vec[cond_addr];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cond_zero_ff <= 1'b1;
        end else begin
            cond_zero_ff <= cond_z;
        end
    end

    // taken purely from the attribute; no flag bits exist
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cond_take_ff <= 1'b0;
        end else begin
            cond_take_ff <= (cond_z == cond_on_zero);
        end
    end

    // ****************
    // read ports
    // ****************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data_a_ff <= URF_ZERO_VAL;
            rd_data_b_ff <= URF_ZERO_VAL;
            rd_data_c_ff <= URF_ZERO_VAL;
        end else begin
            rd_data_a_ff <= rd_val(rd_addr_a);
            rd_data_b_ff <= rd_val(rd_addr_b);
            rd_data_c_ff <= rd_val(rd_addr_c);
        end
    end

    // ****************
    // pointer post-increment
    // ****************
    logic ptr_take;
    urf_data_t ptr_old;
    assign ptr_take = (state_ff == URF_IDLE) && ptr_start;
    assign ptr_old = rd_val(ptr_addr);

    // one access at a time; a start while busy is ignored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= URF_IDLE;
        end else begin
            case (state_ff)
                URF_IDLE: begin
                    if (ptr_start) begin
                        state_ff <= URF_WAIT;
                    end
                end
                URF_WAIT: begin
                    if (mem_done) begin
                        state_ff <= URF_IDLE;
                    end
                end
                default: begin
                    state_ff <= URF_IDLE;
                end
            endcase
        end
    end

    // old pointer drives the access; the sum waits for the done edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ptr_idx_ff <= URF_ZERO_IDX;
            ptr_new_ff <= URF_ZERO_VAL;
            mem_addr_ff <= URF_ZERO_VAL;
        end else if (ptr_take) begin
            ptr_idx_ff <= ptr_addr;
            mem_addr_ff <= ptr_old;
            ptr_new_ff <= ptr_old + ptr_disp;
        end
    end

    // request and busy stand from the start until the done edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mem_req_ff <= 1'b0;
            ptr_busy_ff <= 1'b0;
        end else if (ptr_take) begin
            mem_req_ff <= 1'b1;
            ptr_busy_ff <= 1'b1;
        end else if (ptr_wb) begin
            mem_req_ff <= 1'b0;
            ptr_busy_ff <= 1'b0;
        end
    end
endmodule : urf_top

// File: sim/urf_top_asserts.sv
// checker: port assertions of the register file top
`timescale 1ns/100ps
module urf_top_asserts
    import urf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // reads and condition
    input wire urf_addr_t rd_addr_a,
    input wire urf_data_t rd_data_a_ff,
    input wire urf_addr_t cond_addr,
    input wire logic cond_on_zero,
    input wire logic cond_zero_ff,
    input wire logic cond_take_ff,
    // pointer access
    input wire logic ptr_start,
    input wire logic mem_done,
    input wire urf_data_t mem_addr_ff,
    input wire logic mem_req_ff,
    input wire logic ptr_busy_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_zero_read: assert property (rd_addr_a == 6'h00 |=> rd_data_a_ff == '0)
        else $error("zero register read nonzero");
    chk_cond_take: assert property ($past(rst_b) |->
        cond_take_ff == (cond_zero_ff == $past(cond_on_zero))) else $error("bad take");
    chk_zero_cond: assert property (cond_addr == 6'h00 |=> cond_zero_ff)
        else $error("zero register attribute lost");
    chk_req_rise: assert property (ptr_start && !ptr_busy_ff |=> mem_req_ff)
        else $error("no access request");
    chk_req_hold: assert property (mem_req_ff && !mem_done |=> mem_req_ff)
        else $error("request dropped early");
    chk_req_drop: assert property (mem_req_ff && mem_done |=> !ptr_busy_ff)
        else $error("busy after done");
    chk_addr_hold: assert property (mem_req_ff && !mem_done |=> $stable(mem_addr_ff))
        else $error("access address moved");
    chk_busy_match: assert property (mem_req_ff == ptr_busy_ff)
        else $error("request and busy differ");
    chk_req_cause: assert property ($rose(mem_req_ff) |-> $past(ptr_start))
        else $error("request without start");
    cover property (ptr_start ##1 mem_req_ff ##[1:8] mem_done);
    cover property (cond_take_ff);
    cover property (rd_addr_a == 6'h00);
endmodule : urf_top_asserts
bind urf_top urf_top_asserts i_urf_top_asserts (.*);

// File: sim/urf_mem_model.sv
// model: memory side answering pointer accesses after a set delay
`timescale 1ns/100ps
module urf_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // access handshake
    input wire logic mem_req_ff,
    input wire logic [3:0] lat,
    output logic mem_done
);
    logic [3:0] cnt_ff;
    always_ff @(posedge clk) begin
        if (!rst_b || !mem_req_ff || mem_done) begin
            cnt_ff <= 4'h0;
            mem_done <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
            mem_done <= (cnt_ff == lat);
        end
    end
endmodule : urf_mem_model

// File: sim/urf_top_bench.sv
// bench: directed scenarios for the register file top
`timescale 1ns/100ps
module urf_top_bench;
    import urf_pkg::*;
    logic clk, rst_b, wr_en, wr_carry_en, cond_on_zero, ptr_start, mem_done;
    logic mem_req_ff, ptr_busy_ff, cond_zero_ff, cond_take_ff;
    urf_addr_t rd_addr_a, rd_addr_b, rd_addr_c, wr_addr, cond_addr, ptr_addr;
    urf_data_t rd_data_a_ff, rd_data_b_ff, rd_data_c_ff, wr_data, wr_carry_data;
    urf_data_t ptr_disp, mem_addr_ff;
    logic [3:0] lat;
    int errors = 0;
    int tests_run = 0;
    urf_top i_urf_top (.*);
    urf_mem_model i_urf_mem_model (.*);
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input urf_addr_t a, input urf_data_t d, input logic c, input urf_data_t e);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        wr_carry_en <= c;
        wr_carry_data <= e;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_carry_en <= 1'b0;
    endtask : wr
    task automatic rd(input urf_addr_t a, b, c, input urf_data_t ea, eb, ec, input logic ez);
        @(posedge clk);
        rd_addr_a <= a;
        rd_addr_b <= b;
        rd_addr_c <= c;
        cond_addr <= a;
        cond_on_zero <= ~cond_on_zero;
        @(posedge clk);
        #1;
        chk(rd_data_a_ff === ea && rd_data_b_ff === eb && rd_data_c_ff === ec,
            "read data wrong");
        chk(cond_zero_ff === ez, "zero attribute wrong");
        chk(cond_take_ff === (ez == cond_on_zero), "condition take wrong");
    endtask : rd
    task automatic ptr(input urf_addr_t a, input urf_data_t d, o, input logic [3:0] l);
        @(posedge clk);
        ptr_start <= 1'b1;
        ptr_addr <= a;
        ptr_disp <= d;
        lat <= l;
        @(posedge clk);
        ptr_start <= 1'b0;
        #1;
        chk(mem_req_ff === 1'b1 && ptr_busy_ff === 1'b1 && mem_addr_ff === o,
            "access not started");
        rd(a, 6'h00, 6'h00, o, '0, '0, o == '0);
        for (int i = 0; i < 20 && ptr_busy_ff !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        chk(mem_req_ff === 1'b0 && ptr_busy_ff === 1'b0, "access never ended");
        rd(a, 6'h00, 6'h00, o + d, '0, '0, (o + d) == '0);
    endtask : ptr
    task automatic wrap_up();
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (400) @(posedge clk);
        errors++;
        wrap_up();
    end
    initial begin
        {rst_b, wr_en, wr_carry_en, cond_on_zero, ptr_start, rd_addr_a, rd_addr_b, rd_addr_c,
            wr_addr, cond_addr, ptr_addr, wr_data, wr_carry_data, ptr_disp, lat} = '0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        wr(6'h05, 64'hDEAD_BEEF_0000_0001, 1'b0, '0);
        wr(6'h06, 64'h0, 1'b0, '0);
        rd(6'h05, 6'h06, 6'h00, 64'hDEAD_BEEF_0000_0001, '0, '0, 1'b0);
        rd(6'h06, 6'h00, 6'h05, '0, '0, 64'hDEAD_BEEF_0000_0001, 1'b1);
        wr(6'h00, 64'h1234, 1'b0, '0);
        rd(6'h00, 6'h00, 6'h00, '0, '0, '0, 1'b1);
        wr(6'h0A, 64'h7, 1'b1, 64'h1);
        rd(6'h0B, 6'h0A, 6'h00, 64'h1, 64'h7, '0, 1'b0);
        wr(6'h3F, 64'h9, 1'b1, 64'h5);
        rd(6'h00, 6'h3F, 6'h00, '0, 64'h9, '0, 1'b1);
        wr(6'h03, 64'h100, 1'b0, '0);
        ptr(6'h03, 64'hFFFF_FFFF_FFFF_FFF8, 64'h100, 4'h4);
        ptr(6'h03, 64'h8, 64'hF8, 4'h0);
        wrap_up();
    end
endmodule : urf_top_bench
